// File: design/dtc_debug_port.sv
// Test port logic: forced instruction issue and the two-way comms channel.
// Assumes test pins are asynchronous and much slower than clk_sys_in;
// core-side strobes are one-cycle pulses on clk_sys_in.
`timescale 1ns/100ps
// What this block does
// - Issue held instruction on each idle pass
// - Keep instruction for repeated issue
// - Exec enable clear blocks all issue
// - Ready and precise abort gate issue in exec mode
// - Intest status scan-out clears both abort flags
// - Data chain 34 bits, completion bit 32
// - Direct chain acts as extest chain 4
// - Intest after direct chain uses the earlier selected chain
// - Two transfer registers with full flags
// - Core reads host word, writes outgoing word
// - User disable bit limits channel access
// - Outgoing full flag at status bit 29
// - Incoming full flag at status bit 30
// - Extest chain 5 update loads incoming word
// - Intest chain 5 capture takes outgoing word
// - Valid flag only for new data
// - Write-accepted flag reports stored word
// - Ready gates incoming word loads in exec mode
// - Ready clear blocks updates and issue in exec mode
// - Precise abort disables execution, fakes completion
module dtc_debug_port
	import dtc_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire logic tck_in,
	input wire logic tms_in,
	input wire logic tdi_in,
	input wire logic trst_n_in,
	output logic tdo_out,
	input wire logic debug_state_in,
	input wire logic core_priv_in,
	input wire logic core_rd_in,
	input wire logic core_wr_in,
	input wire logic [31:0] core_wr_data_in,
	input wire logic core_instr_done_in,
	input wire logic core_prec_abort_in,
	input wire logic core_imp_abort_in,
	output logic [31:0] core_rd_data_out,
	output logic core_wr_ready_out,
	output logic core_denied_out,
	output logic [31:0] core_debug_status_ctrl_reg_out,
	output logic [31:0] instr_out,
	output logic instr_issue_out
);
	logic [2:0] tck_sync_r;
	logic [1:0] tms_sync_r, tdi_sync_r, trst_sync_r;
	logic tck_rise, tck_fall, idle_enter_r;
	dtc_tap_e tap_r, tap_nxt;
	logic [IR_W-1:0] ir_r, ir_sr_r;
	logic [4:0] chsel_r, eff_ir, eff_chain;
	logic [DR_W-1:0] sr_r, dr_shift;
	int dr_len;
	logic [31:0] instr_transfer_reg_r, host_to_core_xfer_reg_r, core_to_host_xfer_reg_r;
	logic [31:0] debug_status_ctrl_reg, fifo_data;
	logic itr_loaded_r, core_in_full_r, out_word_full_r, instruction_complete_flag_r;
	logic ready_r, write_accepted_flag_r, exec_en_r, user_dis_r, sticky_prec_r, sticky_imp_r;
	logic exec_mode, core_ok, fifo_ready, fifo_valid, fifo_pop, cap_dr, upd_dr;
	logic cap_data_in, upd_data_ex, upd_instr_ex, cap_status_in, host_accept, issue_now;
	// Test pins pass two flops; a third stage only feeds the clock edge finder
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			tck_sync_r <= 3'h0;
			tms_sync_r <= 2'h3;
			tdi_sync_r <= 2'h0;
			trst_sync_r <= 2'h0;
		end else begin
			tck_sync_r <= {tck_sync_r[1:0], tck_in};
			tms_sync_r <= {tms_sync_r[0], tms_in};
			tdi_sync_r <= {tdi_sync_r[0], tdi_in};
			trst_sync_r <= {trst_sync_r[0], trst_n_in};
		end
	end
	assign tck_rise = tck_sync_r[1] & ~tck_sync_r[2];
	assign tck_fall = ~tck_sync_r[1] & tck_sync_r[2];
	// Test access port state sequence
	always_comb begin
		tap_nxt = tap_r;
		unique case (tap_r)
			TAP_RESET: tap_nxt = tms_sync_r[1] ? TAP_RESET : TAP_IDLE;
			TAP_IDLE: tap_nxt = tms_sync_r[1] ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR: tap_nxt = tms_sync_r[1] ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: tap_nxt = tms_sync_r[1] ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_SHIFT_DR: tap_nxt = tms_sync_r[1] ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_EXIT1_DR: tap_nxt = tms_sync_r[1] ? TAP_UPD_DR : TAP_PAUSE_DR;
			TAP_PAUSE_DR: tap_nxt = tms_sync_r[1] ? TAP_EXIT2_DR : TAP_PAUSE_DR;
			TAP_EXIT2_DR: tap_nxt = tms_sync_r[1] ? TAP_UPD_DR : TAP_SHIFT_DR;
			TAP_UPD_DR: tap_nxt = tms_sync_r[1] ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR: tap_nxt = tms_sync_r[1] ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR: tap_nxt = tms_sync_r[1] ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_SHIFT_IR: tap_nxt = tms_sync_r[1] ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_EXIT1_IR: tap_nxt = tms_sync_r[1] ? TAP_UPD_IR : TAP_PAUSE_IR;
			TAP_PAUSE_IR: tap_nxt = tms_sync_r[1] ? TAP_EXIT2_IR : TAP_PAUSE_IR;
			TAP_EXIT2_IR: tap_nxt = tms_sync_r[1] ? TAP_UPD_IR : TAP_SHIFT_IR;
			TAP_UPD_IR: tap_nxt = tms_sync_r[1] ? TAP_SEL_DR : TAP_IDLE;
		endcase
	end
	always_ff @(posedge clk_sys_in) begin
		if (reset_in || !trst_sync_r[1]) tap_r <= TAP_RESET;
		else if (tck_rise) tap_r <= tap_nxt;
	end
	// direct chain override
	// The select register is left alone, so a later intest finds its chain again
	always_comb begin
		if (ir_r == IR_DIRECT_INSTR) begin
			eff_ir = IR_EXTEST;
			eff_chain = CH_INSTR;
		end else begin
			eff_ir = ir_r;
			eff_chain = chsel_r;
		end
	end
	// Instruction register and chain select
	always_ff @(posedge clk_sys_in) begin
		if (reset_in || !trst_sync_r[1]) begin
			ir_r <= IR_BYPASS;
			ir_sr_r <= IR_CAPTURE_VAL;
			chsel_r <= CH_SEL_RST;
		end else if (tck_rise) begin
			if (tap_r == TAP_RESET) ir_r <= IR_BYPASS;
			if (tap_r == TAP_CAP_IR) ir_sr_r <= IR_CAPTURE_VAL;
			if (tap_r == TAP_SHIFT_IR) ir_sr_r <= {tdi_sync_r[1], ir_sr_r[IR_W-1:1]};
			if (tap_r == TAP_UPD_IR) ir_r <= ir_sr_r;
			if (tap_r == TAP_UPD_DR && ir_r == IR_SCAN_N) chsel_r <= sr_r[4:0];
		end
	end
	// Chain length of the selected path
	always_comb begin
		if (ir_r == IR_SCAN_N) dr_len = LEN_SEL;
		else if (eff_ir != IR_EXTEST && eff_ir != IR_INTEST) dr_len = LEN_BYPASS;
		else if (eff_chain == CH_STATUS) dr_len = LEN_STATUS;
		else if (eff_chain == CH_INSTR) dr_len = LEN_INSTR;
		else if (eff_chain == CH_DATA) dr_len = LEN_DATA;
		else dr_len = LEN_BYPASS;
		dr_shift = {1'b0, sr_r[DR_W-1:1]};
		dr_shift[dr_len-1] = tdi_sync_r[1];
	end
	// Status word as seen by both sides
	// full flags in status
	always_comb begin
		debug_status_ctrl_reg = WORD_RST;
		debug_status_ctrl_reg[ST_PRECISE] = sticky_prec_r;
		debug_status_ctrl_reg[ST_IMPRECISE] = sticky_imp_r;
		debug_status_ctrl_reg[ST_USER_DIS] = user_dis_r;
		debug_status_ctrl_reg[ST_EXEC_EN] = exec_en_r;
		debug_status_ctrl_reg[ST_OUT_FULL] = ~core_wr_ready_out;
		debug_status_ctrl_reg[ST_IN_FULL] = core_in_full_r;
	end
	// Scan event decodes
	assign cap_dr = tck_rise && tap_r == TAP_CAP_DR && ir_r != IR_SCAN_N;
	assign upd_dr = tck_rise && tap_r == TAP_UPD_DR && ir_r != IR_SCAN_N;
	assign cap_data_in = cap_dr && eff_ir == IR_INTEST && eff_chain == CH_DATA;
	assign cap_status_in = cap_dr && eff_ir == IR_INTEST && eff_chain == CH_STATUS;
	assign upd_data_ex = upd_dr && eff_ir == IR_EXTEST && eff_chain == CH_DATA;
	assign upd_instr_ex = upd_dr && eff_ir == IR_EXTEST && eff_chain == CH_INSTR;
	assign exec_mode = debug_state_in & exec_en_r;
	// ready gates updates only in exec mode
	assign host_accept = ~core_in_full_r & (~exec_mode | ready_r);
	// Shift register capture and shift
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			sr_r <= '0;
		end else if (tck_rise && tap_r == TAP_SHIFT_DR) begin
			sr_r <= dr_shift;
		end else if (cap_dr) begin
			sr_r <= '0;
			if (eff_chain == CH_STATUS) begin
				sr_r[31:0] <= debug_status_ctrl_reg;
			end else if (eff_chain == CH_INSTR) begin
				sr_r[31:0] <= instr_transfer_reg_r;
				sr_r[DATA_DONE_BIT] <= instruction_complete_flag_r;
			end else if (eff_chain == CH_DATA) begin
				sr_r[31:0] <= core_to_host_xfer_reg_r;
				sr_r[DATA_DONE_BIT] <= instruction_complete_flag_r;
				sr_r[DATA_FLAG_BIT] <= (eff_ir == IR_INTEST) ? out_word_full_r :
					write_accepted_flag_r;
			end
		end
	end
	// Test data out changes on the falling test clock
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) tdo_out <= 1'b0;
		else if (tck_fall && tap_r == TAP_SHIFT_IR) tdo_out <= ir_sr_r[0];
		else if (tck_fall) tdo_out <= sr_r[0];
	end
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) ready_r <= DONE_RST;
		else if (cap_dr && (eff_chain == CH_INSTR || eff_chain == CH_DATA))
			ready_r <= instruction_complete_flag_r;
	end
	// Status control bits and sticky aborts; a new abort wins over the clear
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			exec_en_r <= 1'b0;
			user_dis_r <= 1'b0;
			sticky_prec_r <= 1'b0;
			sticky_imp_r <= 1'b0;
		end else begin
			if (upd_dr && eff_ir == IR_EXTEST && eff_chain == CH_STATUS) begin
				exec_en_r <= sr_r[ST_EXEC_EN];
				user_dis_r <= sr_r[ST_USER_DIS];
			end
			if (cap_status_in) begin
				sticky_prec_r <= 1'b0;
				sticky_imp_r <= 1'b0;
			end
			if (core_prec_abort_in) sticky_prec_r <= 1'b1;
			if (core_imp_abort_in) sticky_imp_r <= 1'b1;
		end
	end
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			instr_transfer_reg_r <= WORD_RST;
			itr_loaded_r <= 1'b0;
		end else if (upd_instr_ex && (~exec_mode || ready_r)) begin
			instr_transfer_reg_r <= sr_r[31:0];
			itr_loaded_r <= 1'b1;
		end
	end
	// Idle entry acted on one cycle late, so a load on the same test edge has landed
	always_ff @(posedge clk_sys_in) begin
		if (reset_in || !trst_sync_r[1]) idle_enter_r <= 1'b0;
		else idle_enter_r <= tck_rise && tap_nxt == TAP_IDLE && tap_r != TAP_IDLE;
	end
	assign issue_now = idle_enter_r && itr_loaded_r &&
		(eff_ir == IR_INTEST || eff_ir == IR_EXTEST) &&
		(eff_chain == CH_INSTR || eff_chain == CH_DATA) && exec_mode && ready_r && ~sticky_prec_r;
	// Issue pulse and completion tracking
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			instr_issue_out <= 1'b0;
			instr_out <= WORD_RST;
			instruction_complete_flag_r <= DONE_RST;
		end else begin
			instr_issue_out <= issue_now;
			if (issue_now) begin
				instr_out <= instr_transfer_reg_r;
				instruction_complete_flag_r <= 1'b0;
			end
			if (core_instr_done_in || sticky_prec_r) instruction_complete_flag_r <= 1'b1;
		end
	end
	assign core_ok = core_priv_in | ~user_dis_r;
	// incoming word register; a load wins over a core read
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			host_to_core_xfer_reg_r <= WORD_RST;
			core_in_full_r <= 1'b0;
			write_accepted_flag_r <= 1'b0;
			core_rd_data_out <= WORD_RST;
			core_denied_out <= 1'b0;
		end else begin
			core_denied_out <= (core_rd_in | core_wr_in) & ~core_ok;
			if (core_rd_in && core_ok) begin
				core_rd_data_out <= host_to_core_xfer_reg_r;
				core_in_full_r <= 1'b0;
			end
			if (upd_data_ex) begin
				write_accepted_flag_r <= host_accept;
				if (host_accept) begin
					host_to_core_xfer_reg_r <= sr_r[31:0];
					core_in_full_r <= 1'b1;
				end
			end
		end
	end
	assign fifo_pop = fifo_valid & ~out_word_full_r;
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			core_to_host_xfer_reg_r <= WORD_RST;
			out_word_full_r <= 1'b0;
		end else if (fifo_pop) begin
			core_to_host_xfer_reg_r <= fifo_data;
			out_word_full_r <= 1'b1;
		end else if (cap_data_in) begin
			out_word_full_r <= 1'b0;
		end
	end
	dtc_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_out_fifo (
		.clk_in(clk_sys_in),
		.reset_in(reset_in),
		.in_valid_in(core_wr_in & core_ok),
		.in_ready_out(fifo_ready),
		.in_data_in(core_wr_data_in),
		.out_valid_out(fifo_valid),
		.out_ready_in(~out_word_full_r),
		.out_data_out(fifo_data)
	);
	assign core_wr_ready_out = fifo_ready;
	// Status copy for the core
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) core_debug_status_ctrl_reg_out <= WORD_RST;
		else core_debug_status_ctrl_reg_out <= debug_status_ctrl_reg;
	end
	// Checks
	property p_issue_on_idle;
		@(posedge clk_sys_in) disable iff (reset_in) issue_now |=> instr_issue_out;
	endproperty
	a_issue_on_idle: assert property (p_issue_on_idle) else $error("issue missed");
	property p_itr_kept;
		@(posedge clk_sys_in) disable iff (reset_in)
		instr_issue_out |-> itr_loaded_r && instr_out == instr_transfer_reg_r;
	endproperty
	a_itr_kept: assert property (p_itr_kept) else $error("itr lost");
	property p_no_issue_disabled;
		@(posedge clk_sys_in) disable iff (reset_in) !exec_en_r |=> !instr_issue_out;
	endproperty
	a_no_issue_disabled: assert property (p_no_issue_disabled) else $error("issue off");
	property p_abort_clear;
		@(posedge clk_sys_in) disable iff (reset_in)
		cap_status_in && !core_prec_abort_in && !core_imp_abort_in
		|=> !sticky_prec_r && !sticky_imp_r;
	endproperty
	a_abort_clear: assert property (p_abort_clear) else $error("abort kept");
	property p_direct_keeps_sel;
		@(posedge clk_sys_in) disable iff (reset_in)
		tck_rise && tap_r == TAP_UPD_IR && ir_sr_r == IR_DIRECT_INSTR |=> $stable(chsel_r);
	endproperty
	a_direct_keeps_sel: assert property (p_direct_keeps_sel) else $error("sel moved");
	property p_load_incoming;
		@(posedge clk_sys_in) disable iff (reset_in) upd_data_ex && host_accept
		|=> core_in_full_r && host_to_core_xfer_reg_r == $past(sr_r[31:0]);
	endproperty
	a_load_incoming: assert property (p_load_incoming) else $error("no load");
	property p_capture_valid;
		@(posedge clk_sys_in) disable iff (reset_in) cap_data_in && out_word_full_r
		|=> sr_r[DATA_FLAG_BIT] && sr_r[31:0] == $past(core_to_host_xfer_reg_r);
	endproperty
	a_capture_valid: assert property (p_capture_valid) else $error("bad capture");
	property p_ready_blocks;
		@(posedge clk_sys_in) disable iff (reset_in)
		upd_instr_ex && exec_mode && !ready_r |=> $stable(instr_transfer_reg_r);
	endproperty
	a_ready_blocks: assert property (p_ready_blocks) else $error("itr updated");
	property p_abort_no_issue;
		@(posedge clk_sys_in) disable iff (reset_in)
		sticky_prec_r |=> !instr_issue_out ##1 instruction_complete_flag_r;
	endproperty
	a_abort_no_issue: assert property (p_abort_no_issue) else $error("abort issue");
	c_issue: cover property (@(posedge clk_sys_in) disable iff (reset_in) instr_issue_out);
	c_host_word: cover property (@(posedge clk_sys_in) disable iff (reset_in)
		upd_data_ex && host_accept);
	c_fifo_full: cover property (@(posedge clk_sys_in) disable iff (reset_in)
		!core_wr_ready_out);
endmodule : dtc_debug_port

// File: design/dtc_pkg.sv
// Constants and types for the debug port instruction and comms channel block.
// Assumes a single system clock; the test clock is sampled as a plain input.
package dtc_pkg;
	// Instruction register codes
	localparam int IR_W = 5;
	localparam logic [4:0] IR_EXTEST = 5'h00;
	localparam logic [4:0] IR_SCAN_N = 5'h02;
	localparam logic [4:0] IR_INTEST = 5'h0C;
	localparam logic [4:0] IR_DIRECT_INSTR = 5'h1D;
	localparam logic [4:0] IR_BYPASS = 5'h1F;
	localparam logic [4:0] IR_CAPTURE_VAL = 5'h01;
	// Chain select values
	localparam logic [4:0] CH_STATUS = 5'h01;
	localparam logic [4:0] CH_INSTR = 5'h04;
	localparam logic [4:0] CH_DATA = 5'h05;
	localparam logic [4:0] CH_SEL_RST = 5'h00;
	// Chain lengths
	localparam int DR_W = 34;
	localparam int LEN_STATUS = 32;
	localparam int LEN_INSTR = 33;
	localparam int LEN_DATA = 34;
	localparam int LEN_SEL = 5;
	localparam int LEN_BYPASS = 1;
	// Field positions
	localparam int DATA_DONE_BIT = 32;
	localparam int DATA_FLAG_BIT = 33;
	localparam int ST_PRECISE = 6;
	localparam int ST_IMPRECISE = 7;
	localparam int ST_USER_DIS = 12;
	localparam int ST_EXEC_EN = 13;
	localparam int ST_OUT_FULL = 29;
	localparam int ST_IN_FULL = 30;
	// Reset values
	localparam logic DONE_RST = 1'b1;
	localparam logic [31:0] WORD_RST = 32'h0000_0000;
	// Channel FIFO shape
	localparam int FIFO_W = 32;
	localparam int FIFO_D = 16;
	typedef enum logic [3:0] {
		TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
		TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR,
		TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
	} dtc_tap_e;
endpackage : dtc_pkg

// File: design/dtc_fifo.sv
// Word FIFO with valid/ready on both sides.
// Assumes both sides share one clock; ready on the fill side is registered.
`timescale 1ns/100ps
module dtc_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0] count_r;
	logic [AW:0] count_nxt;
	logic push;
	logic pop;

	// Handshakes and occupancy
	assign push = in_valid_in & in_ready_out;
	assign pop = out_valid_out & out_ready_in;
	assign count_nxt = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	assign out_valid_out = (count_r != '0);
	assign out_data_out = mem_r[rd_ptr_r];

	// Pointers, count and registered ready
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
			in_ready_out <= 1'b0;
		end else begin
			if (push) wr_ptr_r <= AW'((32'(wr_ptr_r) + 1) % DEPTH);
			if (pop) rd_ptr_r <= AW'((32'(rd_ptr_r) + 1) % DEPTH);
			count_r <= count_nxt;
			in_ready_out <= (count_nxt != (AW+1)'(DEPTH));
		end
	end

	// Storage
	always_ff @(posedge clk_in) begin
		if (push) mem_r[wr_ptr_r] <= in_data_in;
	end
endmodule : dtc_fifo

// File: verif/dtc_host_model.sv
// Debugger host model: drives the test pins and shifts the IR and data chains.
// Assumes clk_in is the system clock; each test clock phase lasts four cycles.
`timescale 1ns/100ps
module dtc_host_model (
	input wire logic clk_in,
	output logic tck_out,
	output logic tms_out,
	output logic tdi_out,
	output logic trst_n_out,
	input wire logic tdo_in
);
	// Idle levels: test clock still, test reset released
	initial begin
		tck_out = 1'b0;
		tms_out = 1'b1;
		tdi_out = 1'b0;
		trst_n_out = 1'b1;
	end
	// One 80 ns test clock period; tdo is read late in the high phase
	task automatic tick(input logic m, input logic d, output logic q);
		tms_out = m;
		tdi_out = d;
		repeat (4) @(negedge clk_in);
		tck_out = 1'b1;
		repeat (3) @(negedge clk_in);
		q = tdo_in;
		@(negedge clk_in);
		tck_out = 1'b0;
	endtask : tick
	// Five ticks with mode select high, then park in Run-Test/Idle
	task automatic tap_reset;
		logic q;
		repeat (5) tick(1'b1, 1'b0, q);
		tick(1'b0, 1'b0, q);
	endtask : tap_reset
	// whole-chain scans
	// From idle: shift n bits LSB first, update, back to idle; tdi toggles when unused
	task automatic scan(input logic ir, input int n, input logic [33:0] din,
			output logic [33:0] dout);
		logic q;
		dout = '0;
		tick(1'b1, ~din[0], q);
		if (ir)
			tick(1'b1, din[0], q);
		tick(1'b0, ~din[0], q);
		tick(1'b0, din[0], q);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], q);
			dout[i] = q;
		end
		tick(1'b1, ~din[n - 1], q);
		tick(1'b0, din[n - 1], q);
	endtask : scan
endmodule : dtc_host_model

// File: verif/dtc_debug_port_tb.sv
// Self-checking bench: host model on the test pins, core side driven here.
// Assumes the package, design and host model are compiled first.
`timescale 1ns/100ps
module dtc_debug_port_tb
	import dtc_pkg::*;
;
	logic clk_sys_in = 1'b0;
	logic reset_in = 1'b1;
	logic tck, tms, tdi, trst_n, tdo;
	logic debug_state_in = 1'b0;
	logic core_priv_in = 1'b0;
	logic core_rd_in = 1'b0;
	logic core_wr_in = 1'b0;
	logic [31:0] core_wr_data_in = 32'h0;
	logic core_instr_done_in = 1'b0;
	logic core_prec_abort_in = 1'b0;
	logic core_imp_abort_in = 1'b0;
	logic [31:0] core_rd_data_out, core_debug_status_ctrl_reg_out, instr_out;
	logic core_wr_ready_out, core_denied_out, instr_issue_out;
	logic [33:0] so;
	int err_total = 0;
	int tests_run = 0;
	int n_issue = 0;
	int done_wait = 0;
	// 100 MHz system clock
	always #5 clk_sys_in = ~clk_sys_in;
	dtc_debug_port dtc_debug_port_inst (
		.clk_sys_in(clk_sys_in), .reset_in(reset_in), .tck_in(tck), .tms_in(tms),
		.tdi_in(tdi), .trst_n_in(trst_n), .tdo_out(tdo), .debug_state_in(debug_state_in),
		.core_priv_in(core_priv_in), .core_rd_in(core_rd_in), .core_wr_in(core_wr_in),
		.core_wr_data_in(core_wr_data_in), .core_instr_done_in(core_instr_done_in),
		.core_prec_abort_in(core_prec_abort_in), .core_imp_abort_in(core_imp_abort_in),
		.core_rd_data_out(core_rd_data_out), .core_wr_ready_out(core_wr_ready_out),
		.core_denied_out(core_denied_out), .core_debug_status_ctrl_reg_out(core_debug_status_ctrl_reg_out),
		.instr_out(instr_out), .instr_issue_out(instr_issue_out)
	);
	dtc_host_model dtc_host_model_inst (
		.clk_in(clk_sys_in), .tck_out(tck), .tms_out(tms), .tdi_out(tdi),
		.trst_n_out(trst_n), .tdo_in(tdo)
	);
	// Core stand-in: counts issues and reports completion 40 cycles later
	always @(negedge clk_sys_in) begin
		if (instr_issue_out === 1'b1) begin
			n_issue <= n_issue + 1;
			done_wait <= 40;
		end else if (done_wait != 0) begin
			done_wait <= done_wait - 1;
		end
		core_instr_done_in <= (done_wait == 1);
	end
	task automatic chk(input logic [33:0] got, input logic [33:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic waitc(input int n);
		repeat (n) @(negedge clk_sys_in);
	endtask : waitc
	task automatic ir(input logic [4:0] code);
		dtc_host_model_inst.scan(1'b1, IR_W, {29'h0, code}, so);
	endtask : ir
	task automatic dr(input int n, input logic [33:0] v);
		dtc_host_model_inst.scan(1'b0, n, v, so);
	endtask : dr
	task automatic sel(input logic [4:0] ch);
		ir(IR_SCAN_N);
		dr(LEN_SEL, {29'h0, ch});
	endtask : sel
	// One core read strobe; returns at the falling edge after it was taken
	task automatic core_rd(input logic priv);
		core_priv_in = priv;
		core_rd_in = 1'b1;
		@(negedge clk_sys_in);
		core_rd_in = 1'b0;
	endtask : core_rd
	task automatic t_reset;
		waitc(3);
		reset_in = 1'b0;
		waitc(4);
		chk(core_wr_ready_out, 1'b1, "ready after reset");
		chk(core_debug_status_ctrl_reg_out, 32'h0, "status after reset");
		dtc_host_model_inst.tap_reset();
		$display("test reset done");
	endtask : t_reset
	task automatic t_host_to_core;
		sel(CH_DATA);
		ir(IR_EXTEST);
		dr(LEN_DATA, 34'h0_1234_5678);
		dr(LEN_DATA, 34'h0_9ABC_DEF0);
		chk(so[DATA_FLAG_BIT], 1'b1, "first word accepted");
		dr(LEN_DATA, 34'h0_0F0F_0F0F);
		chk(so[DATA_FLAG_BIT], 1'b0, "word refused while full");
		chk(core_debug_status_ctrl_reg_out[ST_IN_FULL], 1'b1, "incoming full");
		core_rd(1'b0);
		waitc(2);
		chk(core_rd_data_out, 32'h1234_5678, "core read word");
		chk(core_debug_status_ctrl_reg_out[ST_IN_FULL], 1'b0, "incoming emptied");
		chk(n_issue, 0, "no issue while disabled");
		$display("test host_to_core done");
	endtask : t_host_to_core
	task automatic t_core_to_host;
		int n = 0;
		for (int i = 0; i < 40; i++) begin
			core_wr_in = (core_wr_ready_out === 1'b1);
			core_wr_data_in = 32'hC0DE_0000 + 32'(n);
			n += int'(core_wr_in);
			@(negedge clk_sys_in);
		end
		core_wr_in = 1'b0;
		chk(n, FIFO_D + 1, "words taken until full");
		chk(core_debug_status_ctrl_reg_out[ST_OUT_FULL], 1'b1, "outgoing full");
		ir(IR_INTEST);
		for (int i = 0; i <= FIFO_D; i++) begin
			dr(LEN_DATA, 34'h0);
			chk({so[33], so[31:0]}, {1'b1, 32'hC0DE_0000 + 32'(i)}, "drained word");
		end
		dr(LEN_DATA, 34'h0);
		chk(so[DATA_FLAG_BIT], 1'b0, "no stale word");
		chk(core_debug_status_ctrl_reg_out[ST_OUT_FULL], 1'b0, "outgoing not full");
		$display("test core_to_host done");
	endtask : t_core_to_host
	task automatic t_exec;
		int n0;
		// debug state before execution is enabled
		debug_state_in = 1'b1;
		sel(CH_STATUS);
		ir(IR_EXTEST);
		dr(LEN_STATUS, 34'h3000);
		waitc(4);
		chk(core_debug_status_ctrl_reg_out[13:12], 2'b11, "enables set");
		core_rd(1'b0);
		chk(core_denied_out, 1'b1, "user access refused");
		waitc(1);
		core_rd(1'b1);
		chk(core_denied_out, 1'b0, "privileged access");
		sel(CH_DATA);
		ir(IR_DIRECT_INSTR);
		waitc(60);
		n0 = n_issue;
		dr(LEN_INSTR, 34'h0_5A5A_0F0F);
		waitc(10);
		chk(n_issue, n0 + 1, "issue after load");
		chk(instr_out, 32'h5A5A_0F0F, "issued instruction");
		ir(IR_INTEST);
		dr(LEN_DATA, 34'h0);
		chk(so[DATA_DONE_BIT], 1'b0, "completion pending");
		waitc(10);
		chk(n_issue, n0 + 2, "no issue while not ready");
		dr(LEN_DATA, 34'h0);
		chk(so[DATA_DONE_BIT], 1'b1, "completion seen");
		waitc(10);
		chk(n_issue, n0 + 3, "issued again");
		chk(instr_out, 32'h5A5A_0F0F, "held instruction");
		core_prec_abort_in = 1'b1;
		core_imp_abort_in = 1'b1;
		@(negedge clk_sys_in);
		core_prec_abort_in = 1'b0;
		core_imp_abort_in = 1'b0;
		waitc(60);
		dr(LEN_DATA, 34'h0);
		chk(so[DATA_DONE_BIT], 1'b1, "completion forced");
		sel(CH_STATUS);
		ir(IR_INTEST);
		dr(LEN_STATUS, 34'h0);
		chk(so[7:6], 2'b11, "abort flags captured");
		waitc(4);
		chk(core_debug_status_ctrl_reg_out[7:6], 2'b00, "abort flags cleared");
		chk(n_issue, n0 + 3, "no issue after abort");
		$display("test exec done");
	endtask : t_exec
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : tally_and_finish
	// Main sequence
	initial begin
		t_reset();
		t_host_to_core();
		t_core_to_host();
		t_exec();
		tally_and_finish();
	end
	// Watchdog: a hang counts as a mismatch
	initial begin
		repeat (100000) @(posedge clk_sys_in);
		err_total++;
		tally_and_finish();
	end
endmodule : dtc_debug_port_tb
